// ===== core/ecs_params.svh
/*
 * Offsets, field positions, response codes and reset values for the
 * statistics counter bank. Assumes byte addresses on a 32-bit
 * AXI4-Lite management bus.
 */
`ifndef ECS_PARAMS_SVH
`define ECS_PARAMS_SVH

// Counter window: four 64-bit counters, two words each
`define ECS_BASE_ADDR        12'h200
`define ECS_RX_BYTES_LOW     12'h200
`define ECS_RX_BYTES_HIGH    12'h204
`define ECS_TX_BYTES_LOW     12'h208
`define ECS_TX_BYTES_HIGH    12'h20C
`define ECS_RX_SHORT_LOW     12'h210
`define ECS_RX_SHORT_HIGH    12'h214
`define ECS_RX_RUNT_LOW      12'h218
`define ECS_RX_RUNT_HIGH     12'h21C

// Address fields inside the window
`define ECS_WORD_SEL_BIT     2
`define ECS_IDX_LSB          3
`define ECS_IDX_MSB          4
`define ECS_WIN_LSB          5

// Counter indices
`define ECS_IDX_RX_BYTES     2'h0
`define ECS_IDX_TX_BYTES     2'h1
`define ECS_IDX_RX_SHORT     2'h2
`define ECS_IDX_RX_RUNT      2'h3
`define ECS_NUM_COUNTERS     4

// Response codes
`define ECS_RESP_OKAY        2'h0
`define ECS_RESP_SLVERR      2'h2
`define ECS_RESP_DECERR      2'h3

// Frame limits and reset values
`define ECS_MIN_FRAME_BYTES  16'h0040
`define ECS_COUNT_RESET      64'h0000_0000_0000_0000
`define ECS_WORD_RESET       32'h0000_0000

`endif

// ===== core/ecs_pkg.sv
/*
 * Types shared by the statistics counter bank.
 * Assumes ecs_params.svh for all numeric constants.
 */
package ecs_pkg;

    // Bus-side sequencing
    typedef enum logic [2:0] {
        ECS_IDLE,
        ECS_ACC_RD,
        ECS_RD_RESP,
        ECS_ACC_WR,
        ECS_WR_RESP
    } ecs_state_t;

    typedef logic [63:0] ecs_count_t;
    typedef logic [1:0]  ecs_idx_t;

endpackage : ecs_pkg

// ===== core/ecs_stats_counters.sv
/*
 * Statistics counter bank: four 64-bit wraparound counters of received
 * and transmitted bytes, undersize and fragment frames, read as two
 * 32-bit words over an AXI4-Lite slave.
 * Assumes frame-end events arrive synchronous to ref_clk, one pulse per
 * frame, and an AXI4-Lite master on the same clock.
 */
// Operation
// - Counters wrap to zero at maximum; software cannot reset them.
// - Reading never clears a counter; only wrap or reconfiguration zero it.
// - All counters are readable over the AXI4-Lite management slave.
// - Writes to counters get SLVERR and leave counters unchanged.
// - Upper word read succeeds only right after lower word of same counter.
// - Received-byte counter at 0x200/0x204, destination address through FCS.
// - Transmitted-byte counter at 0x208/0x20C, destination address through FCS.
// - Well-formed received frames under 64 bytes counted at 0x210/0x214.
// - Received packets under 64 bytes with bad FCS counted at 0x218/0x21C.
`timescale 1ns/1ns
`include "ecs_params.svh"

module ecs_stats_counters
    import ecs_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int LEN_W  = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Frame-end events from the MAC paths
    input  wire logic              rx_frame_end,
    input  wire logic [LEN_W-1:0]  rx_frame_bytes,
    input  wire logic              rx_fcs_good,
    input  wire logic              rx_well_formed,
    input  wire logic              tx_frame_end,
    input  wire logic [LEN_W-1:0]  tx_frame_bytes,
    // AXI4-Lite management slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // Refuse sizes the decode or the short-frame compare cannot serve
    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 10 and 32");
        end
        if (LEN_W < 7 || LEN_W > 16) begin
            $error("LEN_W must lie between 7 and 16");
        end
    end

    localparam logic [LEN_W-1:0] MIN_FRAME = LEN_W'(`ECS_MIN_FRAME_BYTES);
    localparam logic [11:0]      BASE      = `ECS_BASE_ADDR;

    // True when an address falls on a word of the counter window
    function automatic logic ecs_in_window(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] base_ext;
        base_ext = ADDR_W'(BASE);
        ecs_in_window = (a[ADDR_W-1:`ECS_WIN_LSB] == base_ext[ADDR_W-1:`ECS_WIN_LSB])
                        && (a[1:0] == 2'h0);
    endfunction : ecs_in_window

    ecs_state_t        state_r;
    logic              arready_r;
    logic              awready_r;
    logic              wready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic [ADDR_W-1:0] addr_r;
    logic              prev_low_r;
    ecs_idx_t          prev_idx_r;
    logic [31:0]       held_high_r;
    ecs_count_t        cnt_r [`ECS_NUM_COUNTERS];
    ecs_count_t        inc   [`ECS_NUM_COUNTERS];

    logic              rx_short;
    ecs_idx_t          rd_idx;
    logic              rd_high;
    logic              rd_mapped;

    assign rd_idx    = addr_r[`ECS_IDX_MSB:`ECS_IDX_LSB];
    assign rd_high   = addr_r[`ECS_WORD_SEL_BIT];
    assign rd_mapped = ecs_in_window(addr_r);
    assign rx_short  = rx_frame_bytes < MIN_FRAME;

    // Per-frame increments, applied on the frame-end pulse only
    always_comb begin
        inc[`ECS_IDX_RX_BYTES] = rx_frame_end ? 64'(rx_frame_bytes) : 64'h0;
        inc[`ECS_IDX_TX_BYTES] = tx_frame_end ? 64'(tx_frame_bytes) : 64'h0;
        inc[`ECS_IDX_RX_SHORT] = (rx_frame_end && rx_short && rx_fcs_good && rx_well_formed)
                                 ? 64'h1 : 64'h0;
        inc[`ECS_IDX_RX_RUNT]  = (rx_frame_end && rx_short && !rx_fcs_good)
                                 ? 64'h1 : 64'h0;
    end

    // Counters: plain modulo-2^64 add; reset only on reconfiguration,
    // nothing on the bus side touches them
    generate
        for (genvar i = 0; i < `ECS_NUM_COUNTERS; i++) begin : g_cnt
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cnt_r[i] <= `ECS_COUNT_RESET;
                end else begin
                    cnt_r[i] <= cnt_r[i] + inc[i];
                end
            end
        end
    endgenerate

    // Bus sequencing; reads win when both arrive together, one
    // transaction in flight so "previous transaction" is well defined
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ECS_IDLE;
        end else begin
            case (state_r)
                ECS_IDLE: begin
                    if (s_axi_arvalid) begin
                        state_r <= ECS_ACC_RD;
                    end else if (s_axi_awvalid && s_axi_wvalid) begin
                        state_r <= ECS_ACC_WR;
                    end
                end
                ECS_ACC_RD: begin
                    state_r <= ECS_RD_RESP;
                end
                ECS_RD_RESP: begin
                    if (s_axi_rready) begin
                        state_r <= ECS_IDLE;
                    end
                end
                ECS_ACC_WR: begin
                    state_r <= ECS_WR_RESP;
                end
                ECS_WR_RESP: begin
                    if (s_axi_bready) begin
                        state_r <= ECS_IDLE;
                    end
                end
                default: begin
                    state_r <= ECS_IDLE;
                end
            endcase
        end
    end

    // Address latch for the read in progress
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_r <= '0;
        end else if (state_r == ECS_IDLE && s_axi_arvalid) begin
            addr_r <= s_axi_araddr;
        end
    end

    // Ready strobes: one cycle each, in the accept state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            arready_r <= (state_r == ECS_IDLE) && s_axi_arvalid;
            awready_r <= (state_r == ECS_IDLE) && !s_axi_arvalid
                         && s_axi_awvalid && s_axi_wvalid;
            wready_r  <= (state_r == ECS_IDLE) && !s_axi_arvalid
                         && s_axi_awvalid && s_axi_wvalid;
        end
    end

    // Read answer: low word from the counters at accept, high word as held at the paired low read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= `ECS_WORD_RESET;
            rresp_r  <= `ECS_RESP_OKAY;
        end else if (state_r == ECS_ACC_RD) begin
            rvalid_r <= 1'b1;
            if (!rd_mapped) begin
                rdata_r <= `ECS_WORD_RESET;
                rresp_r <= `ECS_RESP_DECERR;
            end else if (!rd_high) begin
                rdata_r <= cnt_r[rd_idx][31:0];
                rresp_r <= `ECS_RESP_OKAY;
            end else if (prev_low_r && prev_idx_r == rd_idx) begin
                rdata_r <= held_high_r;
                rresp_r <= `ECS_RESP_OKAY;
            end else begin
                rdata_r <= `ECS_WORD_RESET;
                rresp_r <= `ECS_RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Lower-word read arms the upper read; any other transaction disarms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_low_r  <= 1'b0;
            prev_idx_r  <= `ECS_IDX_RX_BYTES;
            held_high_r <= `ECS_WORD_RESET;
        end else if (state_r == ECS_ACC_RD) begin
            prev_low_r <= rd_mapped && !rd_high;
            prev_idx_r <= rd_idx;
            if (rd_mapped && !rd_high) begin
                held_high_r <= cnt_r[rd_idx][63:32];
            end
        end else if (state_r == ECS_ACC_WR) begin
            prev_low_r <= 1'b0;
        end
    end

    // Write answer: nothing here is writable, every write is refused
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `ECS_RESP_OKAY;
        end else if (state_r == ECS_ACC_WR) begin
            bvalid_r <= 1'b1;
            bresp_r  <= `ECS_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = arready_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

endmodule : ecs_stats_counters

// ===== test/ecs_stats_checker.sv
/* Assertions on the counter bank's AXI4-Lite slave ports.
   Assumes one clock and a master that holds each request until ready. */
`timescale 1ns/1ns
module ecs_stats_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic       in_win;
    logic       pair_ok;
    logic       armed_r;
    logic [1:0] idx_r;
    // Window decode of the address taken with arready
    assign in_win  = ((s_axi_araddr >> 5) == 'h10) && (s_axi_araddr[1:0] == 2'h0);
    assign pair_ok = armed_r && (idx_r == s_axi_araddr[4:3]);
    // Last transaction was a low read; any write disarms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            idx_r   <= 2'h0;
        end else if (s_axi_awready) begin
            armed_r <= 1'b0;
        end else if (s_axi_arready) begin
            armed_r <= in_win && !s_axi_araddr[2];
            idx_r   <= s_axi_araddr[4:3];
        end
    end
    a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not retired");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read response moved");
    a_write_refused: assert property (s_axi_awready |=>
        s_axi_bvalid && s_axi_bresp == 2'h2) else $error("write not refused");
    a_write_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready differ");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response moved");
    a_unmapped_dec: assert property (s_axi_arready && !in_win |=>
        s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read not DECERR");
    a_low_word_ok: assert property (s_axi_arready && in_win && !s_axi_araddr[2] |=>
        s_axi_rresp == 2'h0) else $error("low word read refused");
    a_lone_high_err: assert property (s_axi_arready && in_win && s_axi_araddr[2]
        && !pair_ok |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("lone high read allowed");
    a_paired_high_ok: assert property (s_axi_arready && in_win && s_axi_araddr[2]
        && pair_ok |=> s_axi_rresp == 2'h0) else $error("paired high read refused");
    c_read_ok: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
    c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : ecs_stats_checker

bind ecs_stats_counters ecs_stats_checker #(.ADDR_W(ADDR_W)) chk_i (.ref_clk, .rst,
    .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== test/ecs_host_model.sv
/* Management host: one AXI4-Lite transaction at a time.
   Assumes registered ready and response outputs on the slave. */
`timescale 1ns/1ns
module ecs_host_model (
    input  wire logic        ref_clk,
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    output logic             hung
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end
    // One address per call; a high read is paired only right after its lower word
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 {s_axi_araddr, s_axi_arvalid} = {a, 1'b1};
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1 && ++n < 40);
        #1 {s_axi_araddr, s_axi_arvalid} = {~a, 1'b0}; // Released address shows garbage
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1 && ++n < 40);
        // Late rready, so the slave must hold its answer one cycle
        #1 s_axi_rready = 1'b1;
        @(posedge ref_clk);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        if (n >= 40) hung = 1'b1;
        #1 s_axi_rready = 1'b0;
    endtask : rd
    // Address and data together, as the slave takes them as a pair
    task automatic wr(input logic [11:0] a, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {a, 32'hA5A5_5A5A, 4'hF};
        {s_axi_awvalid, s_axi_wvalid} = 2'b11;
        do @(posedge ref_clk); while (s_axi_awready !== 1'b1 && ++n < 40);
        #1 {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = {~a, 32'h5A5A_A5A5, 2'b00};
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1 && ++n < 40);
        // Late bready, so the slave must hold its answer one cycle
        #1 s_axi_bready = 1'b1;
        @(posedge ref_clk);
        r = s_axi_bresp;
        if (n >= 40) hung = 1'b1;
        #1 s_axi_bready = 1'b0;
    endtask : wr
endmodule : ecs_host_model

// ===== test/testbench.sv
/* Self-checking bench for the statistics counter bank.
   Assumes the host model drives the bus and the bench drives frame ends. */
`timescale 1ns/1ns
module testbench
    import ecs_pkg::*;
;
    logic ref_clk, rst, rx_frame_end, rx_fcs_good, rx_well_formed, tx_frame_end, hung;
    logic [15:0] rx_frame_bytes, tx_frame_bytes;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    ecs_count_t  ex [4];
    int          fail_count = 0;
    int          comparisons = 0;
    ecs_stats_counters uut (.*);
    ecs_host_model host (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One frame end per call; expectations follow the counting rules
    task automatic ev(input logic rx, tx, input logic [15:0] n, input logic fg, wf);
        @(posedge ref_clk);
        #1 {rx_frame_end, tx_frame_end, rx_frame_bytes, tx_frame_bytes} = {rx, tx, n, n};
        {rx_fcs_good, rx_well_formed} = {fg, wf};
        if (rx) ex[0] += n;
        if (tx) ex[1] += n;
        if (rx && n < 16'h0040 && fg && wf) ex[2]++;
        if (rx && n < 16'h0040 && !fg) ex[3]++;
    endtask : ev
    task automatic all(input string t);
        logic [31:0] v;
        logic [1:0]  q;
        for (int i = 0; i < 4; i++) begin
            host.rd(12'(12'h200 + 8 * i), v, q);
            chk("low word", ex[i][31:0], v);
            chk("low resp", 32'h0, {30'h0, q});
            host.rd(12'(12'h204 + 8 * i), v, q);
            chk("high word", ex[i][63:32], v);
            chk("high resp", 32'h0, {30'h0, q});
        end
        $display("test %s done", t);
    endtask : all
    task automatic rd_err(input logic [11:0] a, input logic [1:0] e);
        host.rd(a, d, r);
        chk("error resp", {30'h0, e}, {30'h0, r});
        chk("error data", 32'h0, d);
    endtask : rd_err
    always @(posedge hung) begin
        fail_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst, rx_frame_end, rx_fcs_good, rx_well_formed, tx_frame_end} = 5'b10000;
        {rx_frame_bytes, tx_frame_bytes} = '0;
        ex = '{default: '0};
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        all("reset");
        all("reread");
        // One frame end every cycle to all ones in the low word; the next frame carries into the high word
        ev(1'b0, 1'b1, 16'hFFFF, 1'b1, 1'b1);
        repeat (65536) @(posedge ref_clk);
        ex[1] += 64'h1_0000 * 64'hFFFF;
        ev(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        host.rd(12'h208, d, r);
        chk("snap low", 32'hFFFF_FFFF, d);
        ev(1'b0, 1'b1, 16'h05DC, 1'b1, 1'b1);
        ev(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        host.rd(12'h20C, d, r);
        chk("snap high", 32'h0, d);
        chk("snap resp", 32'h0, {30'h0, r});
        all("carry");
        // Back-to-back frame ends of every class
        ev(1'b1, 1'b0, 16'h0040, 1'b1, 1'b1);
        ev(1'b1, 1'b0, 16'h003F, 1'b1, 1'b1);
        ev(1'b1, 1'b1, 16'h003F, 1'b0, 1'b0);
        ev(1'b1, 1'b0, 16'h000A, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 16'h05EE, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        all("frames");
        for (int i = 0; i < 9; i++) begin
            host.wr(12'(12'h200 + 4 * i), r);
            chk("write resp", 32'h2, {30'h0, r});
        end
        all("writes");
        host.rd(12'h200, d, r);
        host.wr(12'h200, r);
        rd_err(12'h204, 2'h2);
        rd_err(12'h214, 2'h2);
        host.rd(12'h210, d, r);
        rd_err(12'h21C, 2'h2);
        rd_err(12'h220, 2'h3);
        rd_err(12'h201, 2'h3);
        $display("test refusals done");
        // Reconfiguration clears every counter
        @(posedge ref_clk);
        #1 rst = 1'b1;
        @(posedge ref_clk);
        #1 rst = 1'b0;
        ex = '{default: '0};
        all("second reset");
        wrap_up();
    end
endmodule : testbench
